// [design/thermostat_core.sv]
// Mode, measurement, trip and nonvolatile control of the thermostat sensor
`timescale 1ns/1ps

module thermostat_core #(
	parameter int NV_CYCLES = thermostat_pkg::NV_WRITE_CYCLES, // NV write
	parameter int CONV_CYCLES = thermostat_pkg::CONV_MAX_CYCLES, // Timeout
	parameter int OFF_CYCLES = thermostat_pkg::POWER_DOWN_CYCLES // Power down
) (
	input wire logic clk_sys, // 25 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic vdd_pin, // Supply sense pin, high when powered
	input wire logic dq_in, // Data pin level
	output logic dq_out, // Data pin output value
	output logic dq_oe, // Data pin drive enable, high pulls low
	input wire logic link_pull, // Link layer wants the line low
	output logic dq_rx, // Synchronised line level to link layer
	input wire logic osc_fast_pin, // Low temp-co oscillator pin
	input wire logic osc_gate_pin, // Gate oscillator pin
	input wire logic cmd_valid, // Command strobe from link layer
	input wire thermostat_pkg::link_cmd_s cmd, // Command code and data
	output thermostat_pkg::link_rsp_s rsp, // Read answer
	output logic serial_mode, // High while the pin is a data line
	output logic powered_down // High after long low supply and line
);
	import thermostat_pkg::*;

	// Synchronisers: stage one is read only by stage two
	logic [3:0] sync1; // First stage
	logic [3:0] sync2; // Second stage
	logic [3:0] sync3; // Prior value for edge detection
	logic vdd_ok, dq_s, fast_s, gate_s;
	logic vdd_rise, dq_fall, fast_rise, gate_rise, gate_fall;

	// Nonvolatile contents
	logic [7:0] high_trip_point;
	logic [7:0] low_trip_point;
	logic high_trip_flag;
	logic low_trip_flag;
	logic power_up_mode; // 1 thermostat, 0 serial
	logic output_active_level;
	logic single_conversion_select;
	logic nv_write_busy;
	logic [31:0] nv_timer; // Counts the write time down

	// Volatile state
	logic [7:0] temperature_result;
	logic [8:0] down_counter;
	logic [8:0] slope_accum;
	meas_state_e meas_state;
	logic [31:0] conv_timer; // Cycles spent in a conversion
	logic conv_end; // One-cycle pulse at end of conversion
	logic cont_run; // Continuous conversions running
	logic shot_pend; // One-shot conversion requested
	logic conv_done; // Done status for one-shot
	logic thermo_active; // Thermostat output asserted
	logic thermo_valid; // First compare has happened
	logic serial_override; // Temporary serial entry
	logic run_mode; // Mode taken at power-up, 1 thermostat
	logic line_high_at_off; // Line was high when supply dropped
	logic [4:0] entry_edges; // Line pulses while supply is low
	logic [31:0] off_timer; // Time with supply and line low
	logic conv_go; // Conversions wanted
	logic cmd_ok; // Command accepted in serial mode
	logic nv_write; // A command that writes nonvolatile memory
	logic [7:0] cfg_read; // Configuration register image

	assign vdd_ok = sync2[0];
	assign dq_s = sync2[1];
	assign fast_s = sync2[2];
	assign gate_s = sync2[3];
	assign vdd_rise = sync2[0] & ~sync3[0];
	assign dq_fall = ~sync2[1] & sync3[1];
	assign fast_rise = sync2[2] & ~sync3[2];
	assign gate_rise = sync2[3] & ~sync3[3];
	assign gate_fall = ~sync2[3] & sync3[3];

	// Two flops on every pin, plus a third for edges
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
		end else begin
			sync1 <= {osc_gate_pin, osc_fast_pin, dq_in, vdd_pin};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Mode latched at power-up; override flips it
	assign serial_mode = (run_mode ^ serial_override) == 1'b0;
	assign cmd_ok = cmd_valid & serial_mode & vdd_ok & ~powered_down;
	// Writes while busy are dropped: the host must poll first
	assign nv_write = cmd_ok & ~nv_write_busy &
		(cmd.code == CMD_WRITE_HIGH || cmd.code == CMD_WRITE_LOW ||
		cmd.code == CMD_WRITE_CFG);

	// Supply-low entry sequence and long-low power down
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			serial_override <= 1'b0;
			run_mode <= 1'b0;
			line_high_at_off <= 1'b0;
			entry_edges <= 5'h00;
			off_timer <= 32'h0;
			powered_down <= 1'b0;
		end else if (vdd_ok) begin
			line_high_at_off <= dq_s;
			entry_edges <= 5'h00;
			off_timer <= 32'h0;
			if (vdd_rise) begin
				powered_down <= 1'b0;
				// A rewritten mode bit only acts at the next power-up
				run_mode <= power_up_mode;
				// Exactly 16 pulses toggle, anything else is a power cycle
				if (line_high_at_off && entry_edges == ENTRY_EDGES &&
					!powered_down) begin
					serial_override <= ~serial_override;
				end else begin
					serial_override <= 1'b0;
				end
			end
		end else begin
			if (dq_fall && entry_edges != 5'h1F) begin
				entry_edges <= entry_edges + 5'h01;
			end
			// Timer only runs while the line is low as well
			if (dq_s) begin
				off_timer <= 32'h0;
			end else if (off_timer >= 32'(OFF_CYCLES - 1)) begin
				powered_down <= 1'b1;
			end else begin
				off_timer <= off_timer + 32'h1;
			end
		end
	end

	// Conversion requests from commands; cleared by power loss
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !vdd_ok) begin
			cont_run <= 1'b0;
			shot_pend <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			if (cmd_ok && cmd.code == CMD_START_CONV) begin
				if (single_conversion_select) begin
					shot_pend <= 1'b1;
					conv_done <= 1'b0;
				end else begin
					cont_run <= 1'b1;
				end
			end else if (cmd_ok && cmd.code == CMD_STOP_CONV) begin
				cont_run <= 1'b0;
			end else if (conv_end && shot_pend) begin
				shot_pend <= 1'b0;
				conv_done <= 1'b1;
			end
		end
	end

	// Thermostat mode ignores the conversion-mode bit
	assign conv_go = vdd_ok & ~powered_down &
		(serial_mode ? (cont_run | shot_pend) : 1'b1);

	// Gated count-down loop producing whole degrees
	always_ff @(posedge clk_sys) begin
		conv_end <= 1'b0;
		if (sys_rst || !vdd_ok) begin
			meas_state <= MEAS_IDLE;
			temperature_result <= TEMP_MIN;
			down_counter <= COUNT_BASE;
			slope_accum <= COUNT_BASE;
			conv_timer <= 32'h0;
		end else begin
			unique case (meas_state)
				MEAS_IDLE: begin
					conv_timer <= 32'h0;
					// Skip the end cycle: a one-shot request still stands there
					if (conv_go && !conv_end) begin
						meas_state <= MEAS_ARM;
					end else if (cmd_ok && cmd.code == CMD_LOAD_COUNTER) begin
						down_counter <= slope_accum;
					end
				end
				MEAS_ARM: begin
					// Presets held until the gate opens
					temperature_result <= TEMP_MIN;
					down_counter <= COUNT_BASE;
					slope_accum <= COUNT_BASE;
					conv_timer <= conv_timer + 32'h1;
					if (gate_rise) begin
						meas_state <= MEAS_COUNT;
					end else if (conv_timer >= 32'(CONV_CYCLES - 1)) begin
						meas_state <= MEAS_IDLE;
						conv_end <= 1'b1;
					end
				end
				MEAS_COUNT: begin
					conv_timer <= conv_timer + 32'h1;
					if (gate_fall || conv_timer >= 32'(CONV_CYCLES - 1) ||
						temperature_result == TEMP_MAX) begin
						// Gate closed, timeout or +125 C reached: result is final
						meas_state <= MEAS_IDLE;
						conv_end <= 1'b1;
					end else if (fast_rise) begin
						if (down_counter == 9'h001) begin
							temperature_result <= temperature_result + 8'h01;
							down_counter <= slope_accum + SLOPE_STEP;
							slope_accum <= slope_accum + SLOPE_STEP;
						end else begin
							down_counter <= down_counter - 9'h001;
						end
					end
				end
				default: meas_state <= MEAS_IDLE;
			endcase
		end
	end

	// Thermostat hysteresis; held inactive until first compare
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !vdd_ok) begin
			thermo_active <= 1'b0;
			thermo_valid <= 1'b0;
		end else if (conv_end) begin
			thermo_valid <= 1'b1;
			if ($signed(temperature_result) > $signed(high_trip_point)) begin
				thermo_active <= 1'b1;
			end else if ($signed(temperature_result) <
				$signed(low_trip_point)) begin
				thermo_active <= 1'b0;
			end
		end
	end

	// Nonvolatile contents: survive supply loss, only sys_rst clears
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			high_trip_point <= HIGH_TRIP_RESET;
			low_trip_point <= LOW_TRIP_RESET;
			power_up_mode <= 1'b0;
			output_active_level <= 1'b0;
			single_conversion_select <= 1'b0;
		end else if (nv_write) begin
			unique case (cmd.code)
				CMD_WRITE_HIGH: high_trip_point <= cmd.data;
				CMD_WRITE_LOW: low_trip_point <= cmd.data;
				default: begin
					// Temporary entry never touches the stored mode bit
					power_up_mode <= cmd.data[CFG_MODE];
					output_active_level <= cmd.data[CFG_LEVEL];
					single_conversion_select <= cmd.data[CFG_SINGLE];
				end
			endcase
		end
	end

	// Sticky trip flags; a hardware set beats a host clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			high_trip_flag <= 1'b0;
			low_trip_flag <= 1'b0;
		end else begin
			if (conv_end &&
				$signed(temperature_result) > $signed(high_trip_point)) begin
				high_trip_flag <= 1'b1;
			end else if (nv_write && cmd.code == CMD_WRITE_CFG) begin
				high_trip_flag <= cmd.data[CFG_HIGH_FLAG];
			end
			if (conv_end &&
				$signed(temperature_result) < $signed(low_trip_point)) begin
				low_trip_flag <= 1'b1;
			end else if (nv_write && cmd.code == CMD_WRITE_CFG) begin
				low_trip_flag <= cmd.data[CFG_LOW_FLAG];
			end
		end
	end

	// Write-time model: busy for the full write time
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nv_write_busy <= 1'b0;
			nv_timer <= 32'h0;
		end else if (nv_write) begin
			nv_write_busy <= 1'b1;
			nv_timer <= 32'(NV_CYCLES - 1);
		end else if (nv_timer != 32'h0) begin
			nv_timer <= nv_timer - 32'h1;
		end else begin
			nv_write_busy <= 1'b0;
		end
	end

	// Done reads zero in continuous mode
	assign cfg_read = {conv_done & single_conversion_select, 1'b1,
		nv_write_busy, high_trip_flag, low_trip_flag, power_up_mode,
		output_active_level, single_conversion_select};

	// Read answers, one cycle after the command
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rsp <= '0;
		end else begin
			rsp.valid <= 1'b0;
			if (cmd_ok) begin
				unique case (cmd.code)
					CMD_READ_TEMP: begin
						rsp.valid <= 1'b1;
						rsp.data <= {1'b0, temperature_result};
					end
					CMD_READ_HIGH: begin
						rsp.valid <= 1'b1;
						rsp.data <= {1'b0, high_trip_point};
					end
					CMD_READ_LOW: begin
						rsp.valid <= 1'b1;
						rsp.data <= {1'b0, low_trip_point};
					end
					CMD_READ_CFG: begin
						rsp.valid <= 1'b1;
						rsp.data <= {1'b0, cfg_read};
					end
					CMD_READ_COUNTER: begin
						rsp.valid <= 1'b1;
						rsp.data <= down_counter;
					end
					default: rsp.valid <= 1'b0;
				endcase
			end
		end
	end

	// Pin sharing: open drain only ever pulls low
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !vdd_ok || powered_down) begin
			dq_oe <= 1'b0;
		end else if (serial_mode) begin
			dq_oe <= link_pull;
		end else begin
			// Pull low when the output level should be low
			dq_oe <= ((thermo_active & thermo_valid) ==
				~output_active_level);
		end
	end

	assign dq_out = 1'b0;
	assign dq_rx = dq_s;

endmodule : thermostat_core

// [design/thermostat_pkg.sv]
// Shared constants, command codes and carrier types of the thermostat block
package thermostat_pkg;

	// Clock rate and documented times in their own units
	localparam int CLK_HZ = 25_000_000;
	localparam int NV_WRITE_MS = 10; // Longest nonvolatile write
	localparam int CONV_MAX_MS = 1000; // Longest conversion
	localparam int POWER_DOWN_S = 10; // Supply and line low this long
	// Longest times round down to whole cycles
	localparam int NV_WRITE_CYCLES = (NV_WRITE_MS * (CLK_HZ / 1000));
	localparam int CONV_MAX_CYCLES = (CONV_MAX_MS * (CLK_HZ / 1000));
	localparam int POWER_DOWN_CYCLES = (POWER_DOWN_S * CLK_HZ);

	// Link commands, already decoded to bytes by the link layer
	localparam logic [7:0] CMD_START_CONV = 8'hEE;
	localparam logic [7:0] CMD_STOP_CONV = 8'h22;
	localparam logic [7:0] CMD_READ_COUNTER = 8'hA0;
	localparam logic [7:0] CMD_LOAD_COUNTER = 8'h41;
	localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
	localparam logic [7:0] CMD_WRITE_HIGH = 8'h01;
	localparam logic [7:0] CMD_WRITE_LOW = 8'h02;
	localparam logic [7:0] CMD_READ_HIGH = 8'hA1;
	localparam logic [7:0] CMD_READ_LOW = 8'hA2;
	localparam logic [7:0] CMD_WRITE_CFG = 8'h0C;
	localparam logic [7:0] CMD_READ_CFG = 8'hAC;

	// Configuration register bit positions
	localparam int CFG_DONE = 7;
	localparam int CFG_ONE = 6;
	localparam int CFG_BUSY = 5;
	localparam int CFG_HIGH_FLAG = 4;
	localparam int CFG_LOW_FLAG = 3;
	localparam int CFG_MODE = 2;
	localparam int CFG_LEVEL = 1;
	localparam int CFG_SINGLE = 0;

	// Values after reset (as delivered)
	localparam logic [7:0] HIGH_TRIP_RESET = 8'h00;
	localparam logic [7:0] LOW_TRIP_RESET = 8'h00;
	localparam logic [7:0] TEMP_MIN = 8'hC9; // -55 C
	localparam logic [7:0] TEMP_MAX = 8'h7D; // +125 C
	localparam logic [8:0] COUNT_BASE = 9'h0C8; // Base count for -55 C
	localparam logic [8:0] SLOPE_STEP = 9'h001; // Slope growth per degree
	localparam logic [4:0] ENTRY_EDGES = 5'h10; // Line pulses to re-enter

	// Command from the link layer
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] data;
	} link_cmd_s;

	// Answer to the link layer
	typedef struct packed {
		logic valid;
		logic [8:0] data;
	} link_rsp_s;

	// Measurement loop states
	typedef enum logic [1:0] {
		MEAS_IDLE = 2'b00,
		MEAS_ARM = 2'b01,
		MEAS_COUNT = 2'b10
	} meas_state_e;

endpackage : thermostat_pkg

// [testbench/thermostat_properties.sv]
// Port-level assertions of the thermostat core
`timescale 1ns/1ps
module thermostat_properties #(
	parameter int OFF_CYCLES = 50 // Power-down hold, as in the core
) (
	input wire logic clk_sys, // Clock
	input wire logic sys_rst, // Reset
	input wire logic vdd_pin, // Supply sense
	input wire logic dq_in, // Line level
	input wire logic dq_out, // Pin value
	input wire logic dq_oe, // Pin pull enable
	input wire logic link_pull, // Link layer pull
	input wire logic cmd_valid, // Command strobe
	input wire thermostat_pkg::link_cmd_s cmd, // Command
	input wire thermostat_pkg::link_rsp_s rsp, // Answer
	input wire logic serial_mode, // Pin is data line
	input wire logic powered_down // Device off
);
	import thermostat_pkg::*;
	int vdd_hi; // Steady supply cycles, saturating
	int both_low; // Supply and line both low
	logic is_rd; // Command is a read code
	logic take; // Command the core must accept
	assign is_rd = cmd.code inside {CMD_READ_TEMP, CMD_READ_HIGH,
		CMD_READ_LOW, CMD_READ_CFG, CMD_READ_COUNTER};
	// Supply must pass the synchroniser before commands count
	assign take = cmd_valid && serial_mode && vdd_hi >= 4 && !powered_down;
	// Count steady supply
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !vdd_pin) vdd_hi <= 0;
		else if (vdd_hi < 8) vdd_hi <= vdd_hi + 1;
	end
	// Count supply and line held low together
	always_ff @(posedge clk_sys) begin
		if (sys_rst || vdd_pin || dq_in) both_low <= 0;
		else if (both_low < OFF_CYCLES + 8) both_low <= both_low + 1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_read_answer: assert property (take && is_rd |=> rsp.valid)
		else $error("read not answered next cycle");
	a_answer_cause: assert property (rsp.valid |->
		$past(cmd_valid) && $past(serial_mode))
		else $error("answer without a serial read");
	a_data_width: assert property (rsp.valid &&
		$past(cmd.code) != CMD_READ_COUNTER |-> !rsp.data[8])
		else $error("byte answer uses ninth bit");
	a_temp_range: assert property (rsp.valid &&
		$past(cmd.code) == CMD_READ_TEMP |->
		$signed(rsp.data[7:0]) >= $signed(TEMP_MIN) &&
		$signed(rsp.data[7:0]) <= $signed(TEMP_MAX))
		else $error("temperature out of range");
	a_thermo_silent: assert property (cmd_valid && !serial_mode
		|=> !rsp.valid)
		else $error("answer in thermostat mode");
	a_open_drain: assert property (dq_out == 1'b0)
		else $error("pin drives high");
	a_serial_release: assert property (serial_mode && $past(serial_mode)
		&& !link_pull && !$past(link_pull) |-> !dq_oe)
		else $error("line pulled without link request");
	a_off_hold: assert property ($rose(powered_down) |->
		both_low >= OFF_CYCLES - 2)
		else $error("power-down too early");
	c_read: cover property (rsp.valid);
	c_thermo: cover property ($fell(serial_mode));
	c_off: cover property ($rose(powered_down));
endmodule : thermostat_properties

// [testbench/host_link_model.sv]
// Host side of the pin: pulled-up line, supply, oscillators, mode entry
`timescale 1ns/1ps
module host_link_model (
	input wire logic clk_sys, // Pacing clock
	input wire logic dq_oe, // Device pulls the line low
	output logic vdd_pin, // Supply to the device
	output logic dq_in, // Resolved line level
	output logic osc_fast_pin, // Counted oscillator
	output logic osc_gate_pin // Gate oscillator
);
	logic host_low = 1'b0; // Host pulls the line low
	int gate_hi = 480; // Gate high time in clock periods
	initial vdd_pin = 1'b1;
	initial osc_fast_pin = 1'b0;
	initial osc_gate_pin = 1'b0;
	// Open-drain wire with pull-up, any pull wins
	assign dq_in = ~(dq_oe | host_low);
	// Fast oscillator off the clock grid, about one edge per two cycles
	always #43 osc_fast_pin = ~osc_fast_pin;
	// Gate high time sets the reading: 480 gives one degree, 300 none
	always begin
		#2017 osc_gate_pin = 1'b1;
		#(gate_hi * 40) osc_gate_pin = 1'b0;
	end
	// Supply and host pull change together, then settle
	task automatic supply(input logic on, input logic low);
		@(posedge clk_sys);
		vdd_pin <= on;
		host_low <= low;
		repeat (8) @(posedge clk_sys);
	endtask : supply
	// Supply off with line high, n low pulses, supply back
	task automatic entry(input int n);
		supply(1'b0, 1'b0);
		repeat (n) begin
			host_low <= 1'b1;
			repeat (3) @(posedge clk_sys);
			host_low <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		supply(1'b1, 1'b0);
	endtask : entry
endmodule : host_link_model

// [testbench/tb_top.sv]
// Self-checking bench of the thermostat core
`timescale 1ns/1ps
module tb_top;
	import thermostat_pkg::*;
	logic clk_sys = 1'b0; // 25 MHz clock
	logic sys_rst = 1'b1; // Reset
	logic link_pull; // Link layer pull
	logic cmd_valid = 1'b0; // Command strobe
	link_cmd_s cmd = '0; // Command
	link_rsp_s rsp; // Answer
	logic vdd_pin, dq_in, dq_out, dq_oe, dq_rx, osc_f, osc_g; // Pins
	logic serial_mode, powered_down; // Status
	logic [8:0] d; // Read data
	logic ok; // Answer seen
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #20 clk_sys = ~clk_sys;
	// Short counts keep the run small
	thermostat_core #(.NV_CYCLES(20), .CONV_CYCLES(2000), .OFF_CYCLES(50))
		i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .vdd_pin(vdd_pin),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.link_pull(link_pull), .dq_rx(dq_rx), .osc_fast_pin(osc_f),
		.osc_gate_pin(osc_g), .cmd_valid(cmd_valid), .cmd(cmd),
		.rsp(rsp), .serial_mode(serial_mode),
		.powered_down(powered_down));
	host_link_model i_host (.clk_sys(clk_sys), .dq_oe(dq_oe),
		.vdd_pin(vdd_pin), .dq_in(dq_in), .osc_fast_pin(osc_f),
		.osc_gate_pin(osc_g));
	task automatic chk(input string what, input logic [8:0] seen,
		input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One-cycle strobe; returns at the taking edge
	task automatic send(input logic [7:0] code, input logic [7:0] data);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{code: code, data: data};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
	endtask : send
	// Link layer pull request, applied as a non-blocking update
	task automatic set_pull(input logic want);
		link_pull <= want;
	endtask : set_pull
	// Answer stands right after the taking edge, read 1 ns later
	task automatic rd(input logic [7:0] code, output logic [8:0] v,
		output logic seen);
		send(code, 8'h00);
		#1;
		seen = rsp.valid;
		v = rsp.data;
	endtask : rd
	task automatic expect_rd(input string what, input logic [7:0] code,
		input logic [8:0] mask, input logic [8:0] exp);
		logic [8:0] v;
		logic seen;
		rd(code, v, seen);
		chk(what, {8'h00, seen}, 9'h001);
		chk(what, v & mask, exp);
	endtask : expect_rd
	// Poll a config bit, bounded
	task automatic wait_cfg(input int b, input logic want);
		logic [8:0] c;
		logic seen;
		int n;
		n = 0;
		c = {9{~want}};
		while (c[b] !== want && n < 200) begin
			repeat (10) @(posedge clk_sys);
			rd(CMD_READ_CFG, c, seen);
			n++;
		end
		chk("config bit wait", {8'h00, c[b]}, {8'h00, want});
	endtask : wait_cfg
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	// Hang guard, well above the expected run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		set_pull(1'b0);
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("serial at power-up", {8'h00, serial_mode}, 9'h001);
		expect_rd("high reset", CMD_READ_HIGH, 9'h1FF, 9'h000);
		expect_rd("low reset", CMD_READ_LOW, 9'h1FF, 9'h000);
		expect_rd("cfg reset", CMD_READ_CFG, 9'h07F, 9'h040);
		@(posedge clk_sys);
		set_pull(1'b1);
		repeat (4) @(posedge clk_sys);
		chk("link pull", {7'h00, dq_oe, dq_rx}, 9'h002);
		set_pull(1'b0);
		repeat (4) @(posedge clk_sys);
		chk("link release", {7'h00, dq_oe, dq_rx}, 9'h001);
		send(CMD_WRITE_HIGH, 8'hC9);
		expect_rd("busy bit", CMD_READ_CFG, 9'h020, 9'h020);
		send(CMD_WRITE_HIGH, 8'h55); // Dropped while busy
		wait_cfg(CFG_BUSY, 1'b0);
		expect_rd("high kept", CMD_READ_HIGH, 9'h1FF, 9'h0C9);
		send(CMD_WRITE_LOW, 8'hCA);
		wait_cfg(CFG_BUSY, 1'b0);
		expect_rd("low trip", CMD_READ_LOW, 9'h1FF, 9'h0CA);
		// Continuous runs: one degree above the base
		send(CMD_START_CONV, 8'h00);
		repeat (1500) @(posedge clk_sys);
		expect_rd("done continuous", CMD_READ_CFG, 9'h080, 9'h000);
		send(CMD_STOP_CONV, 8'h00);
		// The register is preset at each start: read once the last one ends
		repeat (1200) @(posedge clk_sys);
		expect_rd("continuous temp", CMD_READ_TEMP, 9'h1FF, 9'h0CA);
		i_host.gate_hi = 300;
		repeat (1200) @(posedge clk_sys);
		// A conversion after the stop would now read the base value
		expect_rd("stopped keeps", CMD_READ_TEMP, 9'h1FF, 9'h0CA);
		// One-shot at the base count; flags cleared by the write
		send(CMD_WRITE_CFG, 8'h01);
		wait_cfg(CFG_BUSY, 1'b0);
		send(CMD_START_CONV, 8'h00);
		expect_rd("done running", CMD_READ_CFG, 9'h080, 9'h000);
		wait_cfg(CFG_DONE, 1'b1);
		expect_rd("one-shot temp", CMD_READ_TEMP, 9'h1FF, 9'h0C9);
		expect_rd("low flag only", CMD_READ_CFG, 9'h018, 9'h008);
		// Idle loop: load copies the slope value into the counter
		send(CMD_LOAD_COUNTER, 8'h00);
		expect_rd("slope count", CMD_READ_COUNTER, 9'h1FF, COUNT_BASE);
		// Thermostat at power-up, output active low, one-shot bit set
		send(CMD_WRITE_CFG, 8'h05);
		expect_rd("still serial", CMD_READ_CFG, 9'h004, 9'h004);
		wait_cfg(CFG_BUSY, 1'b0);
		i_host.gate_hi = 480;
		i_host.entry(0);
		chk("thermostat mode", {8'h00, serial_mode}, 9'h000);
		chk("held before compare", {8'h00, dq_oe}, 9'h000);
		repeat (1500) @(posedge clk_sys);
		chk("output active", {8'h00, dq_oe}, 9'h001);
		rd(CMD_READ_TEMP, d, ok);
		chk("no thermostat read", {8'h00, ok}, 9'h000);
		i_host.gate_hi = 300;
		repeat (2500) @(posedge clk_sys);
		chk("output released", {8'h00, dq_oe}, 9'h000);
		i_host.entry(16);
		chk("temporary serial", {8'h00, serial_mode}, 9'h001);
		expect_rd("mode kept", CMD_READ_CFG, 9'h01C, 9'h01C);
		i_host.entry(16);
		chk("back to thermostat", {8'h00, serial_mode}, 9'h000);
		i_host.supply(1'b0, 1'b1);
		repeat (60) @(posedge clk_sys);
		chk("powered down", {8'h00, powered_down}, 9'h001);
		i_host.supply(1'b1, 1'b0);
		chk("power restored", {8'h00, powered_down}, 9'h000);
		finish_test();
	end
endmodule : tb_top
bind thermostat_core thermostat_properties #(.OFF_CYCLES(OFF_CYCLES))
	i_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .vdd_pin(vdd_pin),
	.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .link_pull(link_pull),
	.cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp),
	.serial_mode(serial_mode), .powered_down(powered_down));
